// file: asr_pkg.sv
// Purpose: shared constants and carrier types of the accelerometer readout block
// Assumes: 20 MHz system clock, 8-bit register port
// Notes:   offsets, field positions, reset values and timing counts live here
`default_nettype none
package asr_pkg;
	// register offsets
	localparam logic [7:0] OFS_X_LOW       = 8'h08;
	localparam logic [7:0] OFS_X_HIGH      = 8'h09;
	localparam logic [7:0] OFS_Y_LOW       = 8'h0A;
	localparam logic [7:0] OFS_Y_HIGH      = 8'h0B;
	localparam logic [7:0] OFS_Z_LOW       = 8'h0C;
	localparam logic [7:0] OFS_Z_HIGH      = 8'h0D;
	localparam logic [7:0] OFS_INT_STATUS2 = 8'h17;
	localparam logic [7:0] OFS_MAIN_CTL    = 8'h1B;
	localparam logic [7:0] OFS_RATE_CTL    = 8'h21;
	localparam logic [7:0] OFS_PIN_CTL     = 8'h22;
	localparam logic [7:0] OFS_ROUTING     = 8'h25;
	localparam logic [7:0] OFS_BUF_CTL2    = 8'h5F;
	localparam logic [7:0] OFS_BUF_READ    = 8'h63;
	// main_control fields
	localparam int MC_OPERATING  = 7;
	localparam int MC_FULL_POWER = 6;
	localparam int MC_READY_EN   = 5;
	localparam int MC_RANGE_LSB  = 3;
	// interrupt_pin_control fields
	localparam int PC_PIN_EN     = 5;
	localparam int PC_ACTIVE_HI  = 4;
	localparam int PC_PULSED     = 3;
	// interrupt_routing and interrupt_status_two fields
	localparam int RT_READY      = 4;
	localparam int RT_FULL       = 6;
	// buffer_control_two fields
	localparam int BC_ENABLE     = 7;
	localparam int BC_RES16      = 6;
	localparam int BC_FULL_IE    = 5;
	// reset values
	localparam logic [7:0] RST_MAIN_CTL = 8'h00;
	localparam logic [7:0] RST_RATE_CTL = 8'h06;
	localparam logic [7:0] RST_PIN_CTL  = 8'h00;
	localparam logic [7:0] RST_ROUTING  = 8'h00;
	localparam logic [7:0] RST_BUF_CTL2 = 8'h00;
	// buffer capacity in bytes
	localparam int         BUF_DEPTH    = 516;
	localparam logic [9:0] BUF_CAP_16   = 10'd516;
	localparam logic [9:0] BUF_CAP_8    = 10'd513;
	// timing
	localparam int         SYS_CLK_HZ   = 20_000_000;
	localparam int         RATE_50_HZ   = 50;
	localparam logic [3:0] RATE_50_CODE = 4'h6;
	localparam int         RATE_50_CYC  = SYS_CLK_HZ / RATE_50_HZ;
	// carriers
	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
	} asr_sample_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} asr_bus_req_t;
	typedef struct packed {
		logic       operating;
		logic       full_power;
		logic [1:0] range_select;
	} asr_sensor_cfg_t;
endpackage
`default_nettype wire

// file: asr_sample_fifo.sv
// Purpose: byte-wide first-in first-out store for buffered samples
// Assumes: one push and one pop per cycle at most, same clock as the host port
// Notes:   capacity input limits fill at or below the storage depth
`default_nettype none
module asr_sample_fifo
	import asr_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       flush,
	input  wire logic       wr_valid,
	input  wire logic [7:0] wr_data,
	output logic            wr_ready,
	input  wire logic       rd_en,
	output logic            rd_valid,
	output logic [7:0]      rd_data,
	output logic [9:0]      level,
	input  wire logic [9:0] capacity
);
	typedef struct packed {
		logic [BUF_DEPTH-1:0][7:0] mem;
		logic [9:0]                wp;
		logic [9:0]                rp;
		logic [9:0]                cnt;
	} asr_fifo_state_t;

	asr_fifo_state_t s_r, s_nxt;
	logic            push, pop;

	// honest flags from the occupancy count
	assign wr_ready = (s_r.cnt < capacity) && !flush;
	assign rd_valid = (s_r.cnt != 10'd0);
	assign rd_data  = s_r.mem[s_r.rp];
	assign level    = s_r.cnt;
	assign push     = wr_valid && wr_ready;
	assign pop      = rd_en && rd_valid && !flush;

	// pointer and count update, flush empties the store
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = wr_data;
			s_nxt.wp = (s_r.wp == 10'(BUF_DEPTH - 1)) ? 10'd0 : s_r.wp + 10'd1;
		end
		if (pop) begin
			s_nxt.rp = (s_r.rp == 10'(BUF_DEPTH - 1)) ? 10'd0 : s_r.rp + 10'd1;
		end
		if (push && !pop) begin
			s_nxt.cnt = s_r.cnt + 10'd1;
		end else if (pop && !push) begin
			s_nxt.cnt = s_r.cnt - 10'd1;
		end
		if (flush) begin
			s_nxt.wp  = 10'd0;
			s_nxt.rp  = 10'd0;
			s_nxt.cnt = 10'd0;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule // asr_sample_fifo
`default_nettype wire

// file: asr_readout.sv
// Purpose: register file, rate ticks, output bytes, sample-ready and buffer-full interrupt
// Assumes: samples arrive on the system clock; host obeys stand-by before reconfiguring
// Notes:   first_interrupt_pin is registered; read data stand one cycle after the strobe
// Functional notes
// - rate code 0x06 gives 50 Hz, reset default
// - 0xC0 operating, full power, 8g, no ready
// - 0xE0 operating, full power, 8g, ready enabled
// - axes as signed low/high bytes, X Y Z
// - pin control 0x30 enables latched active-high pin
// - burst read of outputs clears latched interrupt
// - routing 0x10 sends sample-ready to pin
// - new sample sets ready flag 0x10 in status
// - routing 0x40 sends buffer-full to pin
// - buffer control 0xE0 enables 16-bit FIFO, interrupt
// - FIFO fills until full, then raises interrupt
// - read port returns oldest bytes XL XH YL YH ZL ZH in 16-bit mode, XH YH ZH in 8-bit mode
// - 16-bit buffer holds 516 bytes, 86 samples
// - 8-bit buffer holds 513 bytes, 171 samples
`default_nettype none
module asr_readout
	import asr_pkg::*;
#(
	parameter int RATE_CYC = RATE_50_CYC
) (
	input  wire logic                  sys_clk,
	input  wire logic                  reset_n,
	input  wire asr_pkg::asr_sample_t  accel,
	input  wire asr_pkg::asr_bus_req_t bus_req,
	output logic [7:0]                 bus_rdata,
	output logic                       first_interrupt_pin,
	output asr_pkg::asr_sensor_cfg_t   sensor_cfg
);
	import asr_pkg::*;

	typedef struct packed {
		logic [7:0]      main_control;
		logic [7:0]      sample_rate_control;
		logic [7:0]      interrupt_pin_control;
		logic [7:0]      interrupt_routing;
		logic [7:0]      buffer_control_two;
		asr_sample_t     out;
		asr_sample_t     stage;
		logic            sample_ready_flag;
		logic            int_latch;
		logic            pin;
		logic            full_q;
		logic [7:0]      rdata;
		logic [24:0]     rate_cnt;
		logic [2:0]      push_idx;
		logic            pushing;
		asr_sensor_cfg_t cfg;
	} asr_top_state_t;

	asr_top_state_t s_r, s_nxt;
	logic           tick;
	logic [24:0]    rate_limit;
	logic           wr_ready, rd_valid, buf_full, bfull_evt, ready_evt, any_evt;
	logic           pop_req, burst_end, res16, buf_on;
	logic [7:0]     push_byte, fifo_byte;
	logic [9:0]     level, capacity;

	// rate divider: code 6 gives 50 Hz, each code step doubles the rate
	assign rate_limit = 25'((RATE_CYC * 64) >> s_r.sample_rate_control[3:0]);
	assign tick = s_r.main_control[MC_OPERATING] &&
		((s_r.rate_cnt + 25'd1 >= rate_limit) || (rate_limit == 25'd0));

	// buffer configuration decode
	assign buf_on   = s_r.buffer_control_two[BC_ENABLE];
	assign res16    = s_r.buffer_control_two[BC_RES16];
	assign capacity = res16 ? BUF_CAP_16 : BUF_CAP_8;
	assign buf_full = buf_on && (level >= capacity);
	assign pop_req  = bus_req.rd && (bus_req.addr == OFS_BUF_READ);
	assign burst_end = bus_req.rd && (bus_req.addr == OFS_Z_HIGH);

	// events seen by the interrupt logic
	assign ready_evt = tick && s_r.main_control[MC_READY_EN];
	assign bfull_evt = buf_full && !s_r.full_q && s_r.buffer_control_two[BC_FULL_IE];
	assign any_evt   = (ready_evt && s_r.interrupt_routing[RT_READY]) ||
		(bfull_evt && s_r.interrupt_routing[RT_FULL]);

	// byte picked for the buffer: 16-bit walks all six, 8-bit only high bytes
	always_comb begin
		unique case (s_r.push_idx)
			3'd0:    push_byte = s_r.stage.x[7:0];
			3'd1:    push_byte = s_r.stage.x[15:8];
			3'd2:    push_byte = s_r.stage.y[7:0];
			3'd3:    push_byte = s_r.stage.y[15:8];
			3'd4:    push_byte = s_r.stage.z[7:0];
			default: push_byte = s_r.stage.z[15:8];
		endcase
	end

	asr_sample_fifo u_fifo (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.flush    (!buf_on),
		.wr_valid (s_r.pushing),
		.wr_data  (push_byte),
		.wr_ready (wr_ready),
		.rd_en    (pop_req),
		.rd_valid (rd_valid),
		.rd_data  (fifo_byte),
		.level    (level),
		.capacity (capacity)
	);

	// next-state logic: registers, sampling, buffer feed, interrupt pin
	always_comb begin
		s_nxt = s_r;
		s_nxt.full_q = buf_full;
		// rate counter runs only while operating
		if (!s_r.main_control[MC_OPERATING] || tick) begin
			s_nxt.rate_cnt = 25'd0;
		end else begin
			s_nxt.rate_cnt = s_r.rate_cnt + 25'd1;
		end
		// register writes
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				OFS_MAIN_CTL: s_nxt.main_control          = bus_req.wdata;
				OFS_RATE_CTL: s_nxt.sample_rate_control   = bus_req.wdata;
				OFS_PIN_CTL:  s_nxt.interrupt_pin_control = bus_req.wdata;
				OFS_ROUTING:  s_nxt.interrupt_routing     = bus_req.wdata;
				OFS_BUF_CTL2: s_nxt.buffer_control_two    = bus_req.wdata;
				default:      s_nxt.rdata                 = s_r.rdata;
			endcase
		end
		// sensor front-end settings follow main_control
		s_nxt.cfg.operating    = s_nxt.main_control[MC_OPERATING];
		s_nxt.cfg.full_power   = s_nxt.main_control[MC_FULL_POWER];
		s_nxt.cfg.range_select = s_nxt.main_control[MC_RANGE_LSB +: 2];
		// new sample into the output bytes
		if (tick) begin
			s_nxt.out = accel;
		end
		// feed the buffer one byte a cycle after each tick
		if (s_r.pushing && wr_ready) begin
			if (s_r.push_idx == 3'd5) begin
				s_nxt.pushing = 1'b0;
			end else begin
				s_nxt.push_idx = s_r.push_idx + (res16 ? 3'd1 : 3'd2);
			end
		end
		if (tick && buf_on && !buf_full && !s_r.pushing) begin
			s_nxt.stage    = accel;
			s_nxt.pushing  = 1'b1;
			s_nxt.push_idx = res16 ? 3'd0 : 3'd1;
		end
		if (!buf_on) begin
			s_nxt.pushing = 1'b0;
		end
		// sample-ready flag: set wins over the burst-read clear
		if (burst_end) begin
			s_nxt.sample_ready_flag = 1'b0;
			s_nxt.int_latch         = 1'b0;
		end
		if (pop_req) begin
			s_nxt.int_latch = 1'b0;
		end
		if (ready_evt) begin
			s_nxt.sample_ready_flag = 1'b1;
		end
		if (any_evt) begin
			s_nxt.int_latch = 1'b1;
		end
		// pin: enable, polarity, latched or pulsed
		if (s_r.interrupt_pin_control[PC_PIN_EN]) begin
			s_nxt.pin = (s_r.interrupt_pin_control[PC_PULSED] ? any_evt : s_nxt.int_latch)
				^ !s_r.interrupt_pin_control[PC_ACTIVE_HI];
		end else begin
			s_nxt.pin = 1'b0;
		end
		// read data, valid in the cycle after the strobe
		s_nxt.rdata = 8'h00;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				OFS_X_LOW:       s_nxt.rdata = s_r.out.x[7:0];
				OFS_X_HIGH:      s_nxt.rdata = s_r.out.x[15:8];
				OFS_Y_LOW:       s_nxt.rdata = s_r.out.y[7:0];
				OFS_Y_HIGH:      s_nxt.rdata = s_r.out.y[15:8];
				OFS_Z_LOW:       s_nxt.rdata = s_r.out.z[7:0];
				OFS_Z_HIGH:      s_nxt.rdata = s_r.out.z[15:8];
				OFS_INT_STATUS2: s_nxt.rdata = {1'b0, buf_full, 1'b0,
					s_r.sample_ready_flag, 4'h0};
				OFS_MAIN_CTL:    s_nxt.rdata = s_r.main_control;
				OFS_RATE_CTL:    s_nxt.rdata = s_r.sample_rate_control;
				OFS_PIN_CTL:     s_nxt.rdata = s_r.interrupt_pin_control;
				OFS_ROUTING:     s_nxt.rdata = s_r.interrupt_routing;
				OFS_BUF_CTL2:    s_nxt.rdata = s_r.buffer_control_two;
				OFS_BUF_READ:    s_nxt.rdata = rd_valid ? fifo_byte : 8'h00;
				default:         s_nxt.rdata = 8'h00;
			endcase
		end
	end

	// state register with documented reset values
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.main_control          <= RST_MAIN_CTL;
			s_r.sample_rate_control   <= RST_RATE_CTL;
			s_r.interrupt_pin_control <= RST_PIN_CTL;
			s_r.interrupt_routing     <= RST_ROUTING;
			s_r.buffer_control_two    <= RST_BUF_CTL2;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flip-flops
	assign bus_rdata           = s_r.rdata;
	assign first_interrupt_pin = s_r.pin;
	assign sensor_cfg          = s_r.cfg;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_rate_50;
		(s_r.sample_rate_control[3:0] == RATE_50_CODE) |-> (rate_limit == 25'(RATE_CYC));
	endproperty
	a_rate_50: assert property (p_rate_50) else $error("rate code 6 not 50 Hz");

	property p_ctl_c0;
		(bus_req.wr && bus_req.addr == OFS_MAIN_CTL && bus_req.wdata == 8'hC0) |=> ##1
			(sensor_cfg.operating && sensor_cfg.full_power &&
			sensor_cfg.range_select == 2'd0 && !s_r.main_control[MC_READY_EN]);
	endproperty
	a_ctl_c0: assert property (p_ctl_c0) else $error("0xC0 mode wrong");

	property p_ctl_e0;
		(s_r.main_control == 8'hE0) && tick && !bus_req.wr |=> (s_r.sample_ready_flag &&
			sensor_cfg.operating && sensor_cfg.full_power && sensor_cfg.range_select == 2'd0);
	endproperty
	a_ctl_e0: assert property (p_ctl_e0) else $error("0xE0 gives no ready flag");

	property p_out_bytes;
		tick |=> (s_r.out == $past(accel));
	endproperty
	a_out_bytes: assert property (p_out_bytes) else $error("sample not loaded into outputs");

	property p_latched_pin;
		(s_r.interrupt_pin_control == 8'h30) && $stable(s_r.interrupt_pin_control)
			|-> (first_interrupt_pin == s_r.int_latch);
	endproperty
	a_latched_pin: assert property (p_latched_pin) else $error("latched pin mismatch");

	property p_burst_clear;
		burst_end && !any_evt && !ready_evt |=> (!s_r.int_latch && !s_r.sample_ready_flag);
	endproperty
	a_burst_clear: assert property (p_burst_clear) else $error("burst read no clear");

	property p_ready_route;
		ready_evt && s_r.interrupt_routing == 8'h10 && s_r.interrupt_pin_control == 8'h30
			|=> first_interrupt_pin [*2];
	endproperty
	a_ready_route: assert property (p_ready_route) else $error("ready not on pin");

	property p_full_route;
		$rose(buf_full) && s_r.buffer_control_two[BC_FULL_IE] &&
			s_r.interrupt_routing == 8'h40 && s_r.interrupt_pin_control == 8'h30
			|=> first_interrupt_pin;
	endproperty
	a_full_route: assert property (p_full_route) else $error("full not on pin");

	property p_buf_e0;
		(bus_req.wr && bus_req.addr == OFS_BUF_CTL2 && bus_req.wdata == 8'hE0) |=>
			(buf_on && res16 && s_r.buffer_control_two[BC_FULL_IE] && capacity == 10'd516);
	endproperty
	a_buf_e0: assert property (p_buf_e0) else $error("0xE0 buffer mode wrong");

	property p_no_overfill;
		buf_full && !pop_req |=> (level == $past(level));
	endproperty
	a_no_overfill: assert property (p_no_overfill) else $error("pushed into full buffer");

	property p_pop;
		pop_req && rd_valid && !(s_r.pushing && wr_ready) |=> (level == $past(level) - 10'd1);
	endproperty
	a_pop: assert property (p_pop) else $error("read port did not pop");

	property p_cap16;
		res16 |-> (level <= 10'd516);
	endproperty
	a_cap16: assert property (p_cap16) else $error("16-bit buffer over 516");

	property p_cap8;
		buf_on && !res16 && $stable(res16) |-> (level <= 10'd513);
	endproperty
	a_cap8: assert property (p_cap8) else $error("8-bit buffer over 513");

	property p_append;
		tick && buf_on && !buf_full && !s_r.pushing && !pop_req && $stable(res16)
			|=> ##[5:6] (level == $past(level, 6) + (res16 ? 10'd6 : 10'd3));
	endproperty
	a_append: assert property (p_append) else $error("sample not appended");

	c_ready: cover property (ready_evt ##1 first_interrupt_pin);
	c_full: cover property ($rose(buf_full));
	c_pop: cover property (pop_req && rd_valid);
endmodule // asr_readout
`default_nettype wire

// file: asr_host_model.sv
// Purpose: host-side register master that drives the readout block's plain port
// Assumes: one transfer at a time; strobes change by non-blocking assignment after a rising edge
// Notes:   read data are taken at the edge that closes the answer cycle
`default_nettype none
module asr_host_model (
	input  wire logic                   sys_clk,
	output var  asr_pkg::asr_bus_req_t  bus_req,
	input  wire logic [7:0]             bus_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	import asr_pkg::*;

	// idle port from time zero
	initial bus_req = '0;

	// one write strobe cycle, dropped at the edge that takes it
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge sys_clk);
		bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	// one read strobe cycle; data stand only in the following cycle
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge sys_clk);
		bus_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		@(posedge sys_clk);
		data = bus_rdata;
	endtask

	// stand-by first so no sample is taken with half-written settings
	task automatic reconfig(input logic [7:0] addr, input logic [7:0] data);
		wr(OFS_MAIN_CTL, RST_MAIN_CTL);
		wr(addr, data);
	endtask
endmodule // asr_host_model
`default_nettype wire

// file: accel_sample_readout_buffer_tb.sv
// Purpose: self-checking bench for the readout block: registers, ticks, pin, buffer
// Assumes: shortened rate count, host model drives the register port
// Notes:   expected read bytes queue up at the driver and are checked by a monitor
`default_nettype none
module accel_sample_readout_buffer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import asr_pkg::*;

	localparam int RC = 64;
	logic            sys_clk;
	logic            reset_n;
	asr_sample_t     accel;
	asr_bus_req_t    bus_req;
	logic [7:0]      bus_rdata;
	logic            first_interrupt_pin;
	asr_sensor_cfg_t sensor_cfg;
	int              n_errors;
	int              check_count;
	int              seed;
	int              cyc = 0;
	int              t0;
	int              t1;
	logic            rd_d = 1'b0;
	logic [8:0]      e;
	logic [8:0]      exp_q[$];
	asr_sample_t     smp_q[$];
	logic [7:0]      ra[8] = '{8'h1B, 8'h21, 8'h22, 8'h25, 8'h5F, 8'h17, 8'h30, 8'h63};
	logic [7:0]      re[8] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	asr_readout #(.RATE_CYC(RC)) u_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .accel(accel), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .first_interrupt_pin(first_interrupt_pin),
		.sensor_cfg(sensor_cfg));
	asr_host_model u_host (.sys_clk(sys_clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

	// clock and cycle stamp
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;

	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// pin looked at mid-cycle, after the edge's updates
	task automatic check_pin(input logic exp);
		@(negedge sys_clk);
		check_count++;
		if (first_interrupt_pin !== exp) begin
			n_errors++;
			$display("MISMATCH first_interrupt_pin expected %b seen %b", exp, first_interrupt_pin);
		end
	endtask

	task automatic timeout();
		n_errors++;
		$display("MISMATCH wait expected event seen none");
		stop_test();
	endtask

	// monitor: answer stands one cycle after the read strobe
	always @(posedge sys_clk) begin
		if (rd_d && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (e[8]) check_byte("bus_rdata", e[7:0], bus_rdata);
		end
		rd_d = bus_req.rd;
	end

	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		exp_q.push_back({1'b1, exp});
		u_host.rd(addr, d);
	endtask

	task automatic rd_poll(input logic [7:0] addr, output logic [7:0] d);
		exp_q.push_back(9'h000);
		u_host.rd(addr, d);
	endtask

	task automatic rd_axes(input asr_sample_t s);
		rd_chk(OFS_X_LOW, s.x[7:0]);
		rd_chk(OFS_X_HIGH, s.x[15:8]);
		rd_chk(OFS_Y_LOW, s.y[7:0]);
		rd_chk(OFS_Y_HIGH, s.y[15:8]);
		rd_chk(OFS_Z_LOW, s.z[7:0]);
		rd_chk(OFS_Z_HIGH, s.z[15:8]);
	endtask

	task automatic new_sample();
		logic [63:0] r;
		r = {$random(seed), $random(seed)};
		@(posedge sys_clk);
		accel <= r[47:0];
	endtask

	task automatic wait_rise(output int t);
		int k;
		for (k = 0; k < 300 && first_interrupt_pin !== 1'b1; k++)
			@(negedge sys_clk);
		if (k == 300) timeout();
		t = cyc;
	endtask

	// poll each tick, note the sample, clear the flag; one extra tick must not be kept
	task automatic fill(input int n, input logic res16);
		logic [7:0]  d;
		asr_sample_t s;
		int          k;
		for (int i = 0; i <= n; i++) begin
			k = 0;
			d = 8'h00;
			while (d[4] !== 1'b1) begin
				k = k + 1;
				if (k > 100) timeout();
				rd_poll(OFS_INT_STATUS2, d);
			end
			s = accel;
			if (i < n) smp_q.push_back(s);
			if (i == n - 1) repeat (10) @(posedge sys_clk);
			check_pin(i == n - 1);
			new_sample();
			rd_chk(OFS_Z_HIGH, s.z[15:8]);
		end
		rd_chk(OFS_INT_STATUS2, 8'h40);
		u_host.wr(OFS_MAIN_CTL, RST_MAIN_CTL);
		while (smp_q.size() > 0) begin
			s = smp_q.pop_front();
			if (res16) begin
				rd_chk(OFS_BUF_READ, s.x[7:0]);
				rd_chk(OFS_BUF_READ, s.x[15:8]);
				rd_chk(OFS_BUF_READ, s.y[7:0]);
				rd_chk(OFS_BUF_READ, s.y[15:8]);
				rd_chk(OFS_BUF_READ, s.z[7:0]);
				rd_chk(OFS_BUF_READ, s.z[15:8]);
			end else begin
				rd_chk(OFS_BUF_READ, s.x[15:8]);
				rd_chk(OFS_BUF_READ, s.y[15:8]);
				rd_chk(OFS_BUF_READ, s.z[15:8]);
			end
		end
		rd_chk(OFS_BUF_READ, 8'h00);
	endtask

	// main sequence
	initial begin
		n_errors = 0;
		check_count = 0;
		seed = 94;
		accel = '0;
		reset_n = 1'b0;
		new_sample();
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		// reset values, unmapped place, empty read port
		foreach (ra[i]) rd_chk(ra[i], re[i]);
		u_host.wr(OFS_INT_STATUS2, 8'hFF);
		u_host.wr(8'h30, 8'hFF);
		rd_chk(OFS_INT_STATUS2, 8'h00);
		rd_chk(8'h30, 8'h00);
		// pin disabled stays low, enabled active low idles high
		check_pin(1'b0);
		u_host.wr(OFS_PIN_CTL, 8'h20);
		@(posedge sys_clk);
		check_pin(1'b1);
		// free-running readout with ready generation off
		u_host.reconfig(OFS_PIN_CTL, 8'h30);
		rd_chk(OFS_PIN_CTL, 8'h30);
		u_host.wr(OFS_ROUTING, 8'h10);
		u_host.wr(OFS_MAIN_CTL, 8'hC0);
		repeat (2) @(negedge sys_clk);
		check_byte("sensor_cfg", 8'h0C, {4'h0, sensor_cfg});
		repeat (3 * RC) @(posedge sys_clk);
		check_pin(1'b0);
		rd_chk(OFS_INT_STATUS2, 8'h00);
		rd_axes(accel);
		// pin-driven readout and tick period for two rate codes
		for (int c = 6; c <= 7; c++) begin
			u_host.reconfig(OFS_RATE_CTL, 8'(c));
			u_host.wr(OFS_MAIN_CTL, 8'hE0);
			wait_rise(t0);
			check_byte("sensor_cfg", 8'h0C, {4'h0, sensor_cfg});
			rd_chk(OFS_INT_STATUS2, 8'h10);
			rd_axes(accel);
			check_pin(1'b0);
			wait_rise(t1);
			check_byte("tick_period", 8'(RC >> (c - 6)), 8'(t1 - t0));
			new_sample();
			rd_chk(OFS_Z_HIGH, accel.z[15:8]);
		end
		// 16-bit buffer until full, then 8-bit buffer
		u_host.reconfig(OFS_RATE_CTL, 8'h06);
		u_host.wr(OFS_ROUTING, 8'h40);
		u_host.wr(OFS_BUF_CTL2, 8'hE0);
		rd_chk(OFS_BUF_CTL2, 8'hE0);
		u_host.wr(OFS_MAIN_CTL, 8'hE0);
		fill(86, 1'b1);
		u_host.wr(OFS_BUF_CTL2, 8'h00);
		u_host.wr(OFS_BUF_CTL2, 8'hA0);
		u_host.wr(OFS_MAIN_CTL, 8'hE0);
		fill(171, 1'b0);
		stop_test();
	end
endmodule // accel_sample_readout_buffer_tb
`default_nettype wire
